// file: sniffer_map.vh
`ifndef SNIFFER_MAP_VH
`define SNIFFER_MAP_VH
// Function
// - Async bit time is any programmed divisor, covering 1 Baud to 20 MBaud.
// - Async character length is programmable from 5 up to 9 data bits.
// - With nine data bits only no parity is allowed; others are invalid.
// - Parity none/odd/even/mark/space only flags errors, never alters data.
// - No stop-bit setting; first stop bit ends the character and stores it.
// - Further idle periods are ignored; wait for the next start edge.
// - Scanner measures bit rate on either port (first only in Manchester), then, except in Manchester, finds data bits and parity.
// - Scanning runs on live traffic, restartable anytime, without any capture.
// - SSI frame is delimited by counting the configured clocks per frame.
// - Optional half-clock delay of the SSI sample point, off by default.
// - Double-transmission mode merges a repeated pair of frames into one.
// - SSI scanner measures rate, clocks, monoflop, repeat time; flags irregularities.
// - Manchester type selectable: two phase-encoded, two differential variants.
// - Manchester bit cell equals programmed bit time, half the line clock rate.
// - Manchester bit order per byte selectable, MSB first or LSB first.
// - Manchester scan detects only bit rate; type and order come from setup.
// - Bit rate meter runs continuously on the selected channels, recording or not.
// - Meter source selectable both, first or second channel, or fully off.
// - Each data channel carries up to nine bits plus parity and framing errors.
// - SSI frames longer than a byte are emitted as consecutive bytes.

`define CLK_MHZ 100
`define METER_WIN_MS 1000
`define METER_WIN_CYC (`METER_WIN_MS * 1000 * `CLK_MHZ)
`define SCAN_WIN_MS 200
`define SCAN_WIN_CYC (`SCAN_WIN_MS * 1000 * `CLK_MHZ)
`define SSI_IDLE_NS 2000
`define SSI_IDLE_CYC ((`SSI_IDLE_NS * `CLK_MHZ) / 1000)
`define SCAN_FRAMES 5'd16

`define A_CTRL 8'h00
`define A_DIV 8'h04
`define A_SBITS 8'h08
`define A_RX0 8'h0c
`define A_RX1 8'h10
`define A_METER 8'h14
`define A_SCAN 8'h18
`define A_SDIV 8'h1c
`define A_SPER 8'h20
`define A_SCLKS 8'h24
`define A_SMONO 8'h28
`define A_SREP 8'h2c

`define F_MODE 0
`define F_BITS 2
`define F_PAR 6
`define F_HDLY 9
`define F_DBL 10
`define F_MTYPE 11
`define F_MSB 13
`define F_MSRC 14
`define F_SCAN 16

`define MODE_ASYNC 2'd0
`define MODE_SSI 2'd1
`define MODE_MAN 2'd2
`define P_NONE 3'd0
`define P_ODD 3'd1
`define P_EVEN 3'd2
`define P_MARK 3'd3
`define P_SPACE 3'd4
`define SRC_BOTH 2'd0
`define SRC_FIRST 2'd1
`define SRC_SECOND 2'd2

`define CTRL_RST 16'h0020
`define DIV_RST 27'h0000364
`define SBITS_RST 6'h19
`endif

// file: serial_sniffer.v
`timescale 1ns/100ps
`include "sniffer_map.vh"
module serial_sniffer #(
  parameter METER_WIN = `METER_WIN_CYC,
  parameter SCAN_WIN = `SCAN_WIN_CYC
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire diff_input_first,
  input wire diff_input_second
);
  localparam A_IDLE = 3'd0, A_START = 3'd1, A_DATA = 3'd2, A_PAR = 3'd3, A_STOP = 3'd4;
  localparam C_IDLE = 3'd0, C_RATE = 3'd1, C_LEN = 3'd2, C_PAR = 3'd3, C_DONE = 3'd4;

  function [26:0] sinc;
    input [26:0] x;
    sinc = (&x) ? x : x + 27'd1;
  endfunction

  function par_err;
    input [8:0] d;
    input pb;
    input [2:0] pm;
    reg x;
    begin
      x = (^d) ^ pb;
      case (pm)
        `P_ODD: par_err = ~x;
        `P_EVEN: par_err = x;
        `P_MARK: par_err = ~pb;
        `P_SPACE: par_err = pb;
        default: par_err = 1'b0;
      endcase
    end
  endfunction

  function [3:0] last_zero;
    input [10:0] v;
    integer k;
    begin
      last_zero = 4'd0;
      for (k = 1; k <= 10; k = k + 1)
        if (!v[k])
          last_zero = k[3:0];
    end
  endfunction

  function xor_upto;
    input [10:0] v;
    input [3:0] n;
    integer k;
    begin
      xor_upto = 1'b0;
      for (k = 1; k <= 10; k = k + 1)
        if (k <= n)
          xor_upto = xor_upto ^ v[k];
    end
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  reg [1:0] sy1_q, sy2_q, sy3_q;
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      sy1_q <= 2'b11;
      sy2_q <= 2'b11;
      sy3_q <= 2'b11;
    end
    else
    begin
      sy1_q <= {diff_input_second, diff_input_first};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  wire [1:0] fall = sy3_q & ~sy2_q;
  wire [1:0] rise = ~sy3_q & sy2_q;
  wire [1:0] edg = sy3_q ^ sy2_q;

  // ---------------------------------------------------------------
  // Configuration
  // ---------------------------------------------------------------
  reg [15:0] ctrl_q;
  reg [26:0] div_q;
  reg [5:0] sb_q;
  reg scan_go;
  wire [1:0] mode = ctrl_q[`F_MODE +: 2];
  wire [3:0] nb_raw = ctrl_q[`F_BITS +: 4];
  wire [3:0] nb = (nb_raw < 4'd5) ? 4'd5 : (nb_raw > 4'd9) ? 4'd9 : nb_raw;
  wire [2:0] pm = ctrl_q[`F_PAR +: 3];
  wire par_en = (pm != `P_NONE) && (nb != 4'd9);
  wire cfg_err = (pm != `P_NONE) && (nb == 4'd9);
  wire hdly = ctrl_q[`F_HDLY];
  wire dbl = ctrl_q[`F_DBL];
  wire [1:0] mtype = ctrl_q[`F_MTYPE +: 2];
  wire msb_first = ctrl_q[`F_MSB];
  wire [1:0] msrc = ctrl_q[`F_MSRC +: 2];
  wire [5:0] sbits = (sb_q > 6'd32) ? 6'd32 : (sb_q == 6'd0) ? 6'd1 : sb_q;

  // ---------------------------------------------------------------
  // Async receivers, one per data channel
  // ---------------------------------------------------------------
  wire [1:0] ap, ape, afe;
  wire [17:0] ad;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : arx
      reg [2:0] st_q;
      reg [26:0] cnt_q;
      reg [3:0] idx_q;
      reg [8:0] dat_q;
      reg pb_q, p_q, pe_q, fe_q;
      always @(posedge clk or posedge rst)
        if (rst)
        begin
          st_q <= A_IDLE;
          cnt_q <= 27'd0;
          idx_q <= 4'd0;
          dat_q <= 9'd0;
          pb_q <= 1'b0;
          p_q <= 1'b0;
          pe_q <= 1'b0;
          fe_q <= 1'b0;
        end
        else
        begin
          p_q <= 1'b0;
          if (cnt_q != 27'd0)
            cnt_q <= cnt_q - 27'd1;
          if (mode != `MODE_ASYNC)
            st_q <= A_IDLE;
          else
            case (st_q)
              A_IDLE:
                if (fall[g])
                begin
                  cnt_q <= div_q >> 1;
                  st_q <= A_START;
                end
              A_START:
                if (cnt_q == 27'd0)
                begin
                  st_q <= sy2_q[g] ? A_IDLE : A_DATA;
                  cnt_q <= div_q - 27'd1;
                  idx_q <= 4'd0;
                  dat_q <= 9'd0;
                end
              A_DATA:
                if (cnt_q == 27'd0)
                begin
                  dat_q[idx_q] <= sy2_q[g];
                  idx_q <= idx_q + 4'd1;
                  cnt_q <= div_q - 27'd1;
                  if (idx_q == nb - 4'd1)
                    st_q <= par_en ? A_PAR : A_STOP;
                end
              A_PAR:
                if (cnt_q == 27'd0)
                begin
                  pb_q <= sy2_q[g];
                  cnt_q <= div_q - 27'd1;
                  st_q <= A_STOP;
                end
              A_STOP:
                if (cnt_q == 27'd0)
                begin
                  p_q <= 1'b1;
                  fe_q <= ~sy2_q[g];
                  pe_q <= par_en & par_err(dat_q, pb_q, pm);
                  st_q <= A_IDLE;
                end
              default: st_q <= A_IDLE;
            endcase
        end
      assign ap[g] = p_q;
      assign ape[g] = pe_q;
      assign afe[g] = fe_q;
      assign ad[g*9 +: 9] = dat_q;
    end
  endgenerate

  // ---------------------------------------------------------------
  // SSI decoder and timing scanner
  // ---------------------------------------------------------------
  reg s_act_q, s_fr_q, s_pend_q, s_mrun_q, s_err_q, s_derr_q, ssi_p_q;
  reg [6:0] s_cnt_q, s_rc_q, s_clks_q;
  reg [63:0] s_sh_q;
  reg [26:0] s_tm_q, s_hi_q, s_per_q, s_dly_q, s_rtm_q, s_rep_q, s_mono_q;
  reg [31:0] e_w_q;
  reg [2:0] e_n_q;
  reg [7:0] e_b_q;
  reg [1:0] slot_v_q;
  wire ssi_on = (mode == `MODE_SSI);
  wire [6:0] tgt = dbl ? {sbits, 1'b0} : {1'b0, sbits};
  wire smp = s_fr_q & ((rise[0] & ~hdly) | (s_pend_q & (s_dly_q == 27'd0)));
  wire [63:0] nsh = {s_sh_q[62:0], sy2_q[1]};
  wire [63:0] msk = (64'h1 << sbits) - 64'h1;
  wire [63:0] first_w = nsh >> sbits;
  localparam [27:0] IDLE_GAP = `SSI_IDLE_CYC;
  wire [27:0] thr = {s_per_q, 1'b0} + IDLE_GAP;
  wire [4:0] eidx = {e_n_q[1:0] - 2'd1, 3'b000};
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      s_act_q <= 1'b0;
      s_fr_q <= 1'b0;
      s_pend_q <= 1'b0;
      s_mrun_q <= 1'b0;
      s_err_q <= 1'b0;
      s_derr_q <= 1'b0;
      ssi_p_q <= 1'b0;
      s_cnt_q <= 7'd0;
      s_rc_q <= 7'd0;
      s_clks_q <= 7'd0;
      s_sh_q <= 64'h0;
      s_tm_q <= 27'd0;
      s_hi_q <= 27'd0;
      s_per_q <= 27'd0;
      s_dly_q <= 27'd0;
      s_rtm_q <= 27'd0;
      s_rep_q <= 27'd0;
      s_mono_q <= 27'd0;
      e_w_q <= 32'h0;
      e_n_q <= 3'd0;
      e_b_q <= 8'h0;
    end
    else
    begin
      ssi_p_q <= 1'b0;
      s_tm_q <= sinc(s_tm_q);
      s_rtm_q <= sinc(s_rtm_q);
      s_hi_q <= (rise[0] || !sy2_q[0]) ? 27'd0 : sinc(s_hi_q);
      if (scan_go)
      begin
        s_err_q <= 1'b0;
        s_derr_q <= 1'b0;
      end
      if (!ssi_on)
      begin
        s_act_q <= 1'b0;
        s_fr_q <= 1'b0;
        s_pend_q <= 1'b0;
        e_n_q <= 3'd0;
      end
      else
      begin
        if (fall[0] && !s_act_q)
        begin
          s_act_q <= 1'b1;
          s_fr_q <= 1'b1;
          s_cnt_q <= 7'd0;
          s_rc_q <= 7'd0;
          s_rep_q <= s_rtm_q;
          s_rtm_q <= 27'd1;
          s_tm_q <= 27'd1;
        end
        else if (fall[0])
        begin
          // Restart at one so a period of N cycles reads as N
          s_per_q <= s_tm_q;
          s_tm_q <= 27'd1;
        end
        if (rise[0] && s_act_q)
          s_rc_q <= s_rc_q + 7'd1;
        if (rise[0] && hdly && s_fr_q)
        begin
          s_pend_q <= 1'b1;
          s_dly_q <= s_per_q >> 1;
        end
        else if (s_pend_q && s_dly_q != 27'd0)
          s_dly_q <= s_dly_q - 27'd1;
        if (smp)
        begin
          s_pend_q <= 1'b0;
          s_sh_q <= nsh;
          s_cnt_q <= s_cnt_q + 7'd1;
          if (s_cnt_q + 7'd1 == tgt)
          begin
            s_fr_q <= 1'b0;
            e_w_q <= dbl ? first_w[31:0] : nsh[31:0];
            e_n_q <= sbits[5:3] + {2'b00, |sbits[2:0]};
            if (dbl && ((first_w ^ nsh) & msk) != 64'h0)
              s_derr_q <= 1'b1;
          end
        end
        if (s_act_q && {1'b0, s_hi_q} > thr)
        begin
          s_act_q <= 1'b0;
          s_fr_q <= 1'b0;
          s_clks_q <= s_rc_q;
          if (s_rc_q != tgt)
            s_err_q <= 1'b1;
          if (sy2_q[1])
          begin
            s_mono_q <= s_hi_q;
            s_err_q <= 1'b1;
          end
          else
            s_mrun_q <= 1'b1;
        end
        // Emitter waits for the slot, so a slow reader delays bytes; a new frame replaces unsent ones
        if (e_n_q != 3'd0 && !slot_v_q[0] && !ssi_p_q)
        begin
          e_b_q <= e_w_q[eidx +: 8];
          e_n_q <= e_n_q - 3'd1;
          ssi_p_q <= 1'b1;
        end
      end
      if (s_mrun_q && rise[1])
      begin
        s_mono_q <= s_hi_q;
        s_mrun_q <= 1'b0;
      end
    end

  // ---------------------------------------------------------------
  // Manchester decoder
  // ---------------------------------------------------------------
  reg [26:0] m_tm_q;
  reg m_sync_q, m_bnd_q, m_p_q;
  reg [7:0] m_b_q, m_out_q;
  reg [2:0] m_n_q;
  wire [26:0] m_3q = (div_q >> 1) + (div_q >> 2);
  wire m_mid = edg[0] & (~m_sync_q | (m_tm_q > m_3q));
  reg m_bit;
  always @*
    case (mtype)
      2'd0: m_bit = sy2_q[0];
      2'd1: m_bit = ~sy2_q[0];
      2'd2: m_bit = ~m_bnd_q;
      default: m_bit = m_bnd_q;
    endcase
  wire [7:0] m_nb = msb_first ? {m_b_q[6:0], m_bit} : {m_bit, m_b_q[7:1]};
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      m_tm_q <= 27'd0;
      m_sync_q <= 1'b0;
      m_bnd_q <= 1'b0;
      m_p_q <= 1'b0;
      m_b_q <= 8'h0;
      m_out_q <= 8'h0;
      m_n_q <= 3'd0;
    end
    else
    begin
      m_p_q <= 1'b0;
      m_tm_q <= sinc(m_tm_q);
      if (mode != `MODE_MAN)
      begin
        m_sync_q <= 1'b0;
        m_n_q <= 3'd0;
      end
      else if (m_mid)
      begin
        m_tm_q <= 27'd0;
        m_sync_q <= 1'b1;
        m_bnd_q <= 1'b0;
        m_b_q <= m_nb;
        m_n_q <= m_n_q + 3'd1;
        if (m_n_q == 3'd7)
        begin
          m_out_q <= m_nb;
          m_p_q <= 1'b1;
        end
      end
      else if (edg[0])
        m_bnd_q <= 1'b1;
      else if (m_sync_q && {1'b0, m_tm_q} > {div_q, 1'b0})
      begin
        // Two silent cells end the frame; a partial byte is dropped
        m_sync_q <= 1'b0;
        m_n_q <= 3'd0;
      end
    end

  // ---------------------------------------------------------------
  // Output slots
  // ---------------------------------------------------------------
  reg [17:0] slot_d_q;
  reg [1:0] slot_pe_q, slot_fe_q, slot_ov_q;
  reg [1:0] pop;
  wire [1:0] psh;
  wire [17:0] pdat;
  assign psh[1] = ap[1];
  assign psh[0] = (mode == `MODE_ASYNC) ? ap[0] : ssi_on ? ssi_p_q :
                  (mode == `MODE_MAN) ? m_p_q : 1'b0;
  assign pdat[17:9] = ad[17:9];
  assign pdat[8:0] = (mode == `MODE_ASYNC) ? ad[8:0] :
                     ssi_on ? {1'b0, e_b_q} : {1'b0, m_out_q};
  wire [1:0] ppe = (mode == `MODE_ASYNC) ? ape : {ape[1], 1'b0};
  wire [1:0] pfe = (mode == `MODE_ASYNC) ? afe : {afe[1], 1'b0};
  integer i;
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      slot_d_q <= 18'd0;
      slot_pe_q <= 2'b00;
      slot_fe_q <= 2'b00;
      slot_ov_q <= 2'b00;
      slot_v_q <= 2'b00;
    end
    else
      for (i = 0; i < 2; i = i + 1)
        if (psh[i])
        begin
          slot_v_q[i] <= 1'b1;
          slot_d_q[i*9 +: 9] <= pdat[i*9 +: 9];
          slot_pe_q[i] <= ppe[i];
          slot_fe_q[i] <= pfe[i];
          slot_ov_q[i] <= slot_v_q[i] & ~pop[i];
        end
        else if (pop[i])
        begin
          slot_v_q[i] <= 1'b0;
          slot_ov_q[i] <= 1'b0;
        end

  // ---------------------------------------------------------------
  // Bit rate meter
  // ---------------------------------------------------------------
  reg [26:0] mt_q, mmin_q, meter_q;
  reg [31:0] mw_q;
  wire me = (msrc == `SRC_BOTH) ? |edg : (msrc == `SRC_FIRST) ? edg[0] :
            (msrc == `SRC_SECOND) ? edg[1] : 1'b0;
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      mt_q <= {27{1'b1}};
      mmin_q <= {27{1'b1}};
      meter_q <= 27'd0;
      mw_q <= 32'd0;
    end
    else
    begin
      mt_q <= me ? 27'd1 : sinc(mt_q);
      mw_q <= mw_q + 32'd1;
      if (mw_q == METER_WIN - 1)
      begin
        mw_q <= 32'd0;
        meter_q <= (&mmin_q) ? 27'd0 : mmin_q;
        mmin_q <= {27{1'b1}};
      end
      else if (me && mt_q < mmin_q)
        mmin_q <= mt_q;
    end

  // ---------------------------------------------------------------
  // Parameter scanner
  // ---------------------------------------------------------------
  reg [2:0] sc_st_q;
  reg [31:0] sw_q;
  reg [26:0] stm_q, smin_q, sdiv_q, sf_cnt_q;
  reg sf_act_q, sf_done_q;
  reg [3:0] sf_idx_q, sc_len_q, sc_bits_q;
  reg [10:0] sf_v_q;
  reg [4:0] sc_fr_q, sc_ne_q, sc_no_q;
  reg [2:0] sc_par_q;
  // Either port except in Manchester mode, which uses the first only: idle-high lines are merged so traffic on one suffices
  wire sl_now = (mode == `MODE_MAN) ? sy2_q[0] : &sy2_q;
  wire sl_prev = (mode == `MODE_MAN) ? sy3_q[0] : &sy3_q;
  wire sedge = sl_now ^ sl_prev;
  wire sx = xor_upto(sf_v_q, sc_len_q);
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      sc_st_q <= C_IDLE;
      sw_q <= 32'd0;
      stm_q <= {27{1'b1}};
      smin_q <= {27{1'b1}};
      sdiv_q <= 27'd0;
      sf_cnt_q <= 27'd0;
      sf_act_q <= 1'b0;
      sf_done_q <= 1'b0;
      sf_idx_q <= 4'd0;
      sf_v_q <= 11'h7ff;
      sc_len_q <= 4'd0;
      sc_bits_q <= 4'd0;
      sc_fr_q <= 5'd0;
      sc_ne_q <= 5'd0;
      sc_no_q <= 5'd0;
      sc_par_q <= `P_NONE;
    end
    else
    begin
      sf_done_q <= 1'b0;
      stm_q <= sedge ? 27'd1 : sinc(stm_q);
      // Frames must leave a gap: back-to-back short characters lengthen the scan
      if (sf_act_q && sf_cnt_q != 27'd0)
        sf_cnt_q <= sf_cnt_q - 27'd1;
      else if (sf_act_q)
      begin
        sf_v_q[sf_idx_q] <= sl_now;
        sf_idx_q <= sf_idx_q + 4'd1;
        sf_cnt_q <= sdiv_q - 27'd1;
        if (sf_idx_q == 4'd10)
        begin
          sf_act_q <= 1'b0;
          sf_done_q <= 1'b1;
        end
      end
      else if (sl_prev && !sl_now && (sc_st_q == C_LEN || sc_st_q == C_PAR))
      begin
        sf_act_q <= 1'b1;
        sf_idx_q <= 4'd1;
        sf_cnt_q <= sdiv_q + (sdiv_q >> 1);
      end
      if (scan_go)
      begin
        sc_st_q <= C_RATE;
        sw_q <= 32'd0;
        smin_q <= {27{1'b1}};
        sf_act_q <= 1'b0;
      end
      else
        case (sc_st_q)
          C_RATE:
          begin
            sw_q <= sw_q + 32'd1;
            if (sedge && stm_q < smin_q)
              smin_q <= stm_q;
            if (sw_q == SCAN_WIN - 1)
            begin
              sc_fr_q <= 5'd0;
              sc_len_q <= 4'd0;
              sc_ne_q <= 5'd0;
              sc_no_q <= 5'd0;
              if (&smin_q)
              begin
                sdiv_q <= 27'd0;
                sc_st_q <= C_DONE;
              end
              else if (mode == `MODE_MAN)
              begin
                sdiv_q <= {smin_q[25:0], 1'b0};
                sc_st_q <= C_DONE;
              end
              else
              begin
                sdiv_q <= smin_q;
                sc_st_q <= C_LEN;
              end
            end
          end
          C_LEN:
            if (sf_done_q)
            begin
              if (last_zero(sf_v_q) > sc_len_q)
                sc_len_q <= last_zero(sf_v_q);
              sc_fr_q <= sc_fr_q + 5'd1;
              if (sc_fr_q == `SCAN_FRAMES - 5'd1)
              begin
                sc_fr_q <= 5'd0;
                sc_st_q <= C_PAR;
              end
            end
          C_PAR:
            if (sf_done_q)
            begin
              sc_fr_q <= sc_fr_q + 5'd1;
              if (sx)
                sc_no_q <= sc_no_q + 5'd1;
              else
                sc_ne_q <= sc_ne_q + 5'd1;
              if (sc_fr_q == `SCAN_FRAMES - 5'd1)
                sc_st_q <= C_DONE;
            end
          C_IDLE, C_DONE: sc_st_q <= sc_st_q;
          default: sc_st_q <= C_IDLE;
        endcase
      if (sc_st_q == C_PAR && sf_done_q && sc_fr_q == `SCAN_FRAMES - 5'd1)
      begin
        if (sc_len_q >= 4'd6 && (sc_no_q == 5'd0 && !sx))
        begin
          sc_bits_q <= sc_len_q - 4'd1;
          sc_par_q <= `P_EVEN;
        end
        else if (sc_len_q >= 4'd6 && (sc_ne_q == 5'd0 && sx))
        begin
          sc_bits_q <= sc_len_q - 4'd1;
          sc_par_q <= `P_ODD;
        end
        else
        begin
          sc_bits_q <= (sc_len_q < 4'd5) ? 4'd5 : (sc_len_q > 4'd9) ? 4'd9 : sc_len_q;
          sc_par_q <= `P_NONE;
        end
      end
    end

  // ---------------------------------------------------------------
  // APB slave: one wait state, read side effects on the data capture edge
  // ---------------------------------------------------------------
  reg [31:0] prdata_q, rmux;
  reg pready_q, pslverr_q, hit;
  wire ld = psel & penable & ~pready_q;
  wire wr = psel & penable & pready_q & pwrite;
  always @*
  begin
    hit = 1'b1;
    rmux = 32'h0;
    pop = 2'b00;
    scan_go = wr & (paddr == `A_CTRL) & pwdata[`F_SCAN];
    case (paddr)
      `A_CTRL: rmux = {16'h0, ctrl_q};
      `A_DIV: rmux = {5'h0, div_q};
      `A_SBITS: rmux = {26'h0, sb_q};
      `A_RX0: rmux = {19'h0, slot_ov_q[0], slot_v_q[0], slot_fe_q[0], slot_pe_q[0],
                      slot_d_q[8:0]};
      `A_RX1: rmux = {19'h0, slot_ov_q[1], slot_v_q[1], slot_fe_q[1], slot_pe_q[1],
                      slot_d_q[17:9]};
      `A_METER: rmux = {5'h0, meter_q};
      `A_SCAN: rmux = {20'h0, s_derr_q, s_err_q, cfg_err, sc_par_q, sc_bits_q,
                       sc_st_q == C_DONE, sc_st_q != C_IDLE && sc_st_q != C_DONE};
      `A_SDIV: rmux = {5'h0, sdiv_q};
      `A_SPER: rmux = {5'h0, s_per_q};
      `A_SCLKS: rmux = {25'h0, s_clks_q};
      `A_SMONO: rmux = {5'h0, s_mono_q};
      `A_SREP: rmux = {5'h0, s_rep_q};
      default: hit = 1'b0;
    endcase
    if (ld && !pwrite && paddr == `A_RX0)
      pop[0] = 1'b1;
    if (ld && !pwrite && paddr == `A_RX1)
      pop[1] = 1'b1;
  end
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      ctrl_q <= `CTRL_RST;
      div_q <= `DIV_RST;
      sb_q <= `SBITS_RST;
    end
    else
    begin
      pready_q <= ld;
      pslverr_q <= ld & ~hit;
      if (ld)
        prdata_q <= pwrite ? 32'h0 : rmux;
      if (wr && paddr == `A_CTRL)
        ctrl_q <= pwdata[15:0];
      if (wr && paddr == `A_DIV)
        div_q <= pwdata[26:0];
      if (wr && paddr == `A_SBITS)
        sb_q <= pwdata[5:0];
    end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule

// file: sniffer_monitor.sv
`timescale 1ns/100ps
module sniffer_monitor #(parameter METER_WIN = 2000, parameter SCAN_WIN = 2000) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire rd = pready && !pwrite;
  AST_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("slow ready");
  AST_ONE: assert property (pready |=> !pready)
    else $error("long ready");
  AST_CAUSE: assert property (pready |-> $past(penable))
    else $error("stray ready");
  AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error");
  AST_WR: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write data");
  AST_RX: assert property (rd && (paddr == 8'h0c || paddr == 8'h10) |-> !prdata[31:13])
    else $error("rx width");
  AST_BITS: assert property (rd && paddr == 8'h00 |-> prdata[5:2] inside {[5:9]})
    else $error("char length");
  AST_SBITS: assert property (rd && paddr == 8'h08 |-> prdata[5:0] inside {[1:32]})
    else $error("frame clocks");
endmodule
bind serial_sniffer sniffer_monitor #(.METER_WIN(METER_WIN), .SCAN_WIN(SCAN_WIN)) u_mon (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// file: line_talker.sv
`timescale 1ns/100ps
module line_talker (
  output logic line
);
  // Idle high; LSB first, 80 ns a bit, phase free of the bench clock
  initial line = 1'b1;
  task automatic send(logic [9:0] f, int n, logic stop);
    #3 line = 1'b0;
    for (int k = 0; k < n; k++)
      #80 line = f[k];
    #80 line = stop;
    #80 line = 1'b1;
    #160;
  endtask
  // Two half-bit levels a then b per bit, highest bit first, line high after
  task automatic wave(logic [31:0] a, logic [31:0] b, int n);
    #3;
    for (int k = n - 1; k >= 0; k--)
    begin
      #40 line = a[k];
      #40 line = b[k];
    end
    #40 line = 1'b1;
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, perr, line_a, line_b, pb;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [8:0] d;
  logic [9:0] f;
  integer seed = 32'ha06d489f;
  int err_count = 0, total_checks = 0, i, n, p;
  serial_sniffer #(.METER_WIN(2000), .SCAN_WIN(2000)) u_dut (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .diff_input_first(line_a),
    .diff_input_second(line_b));
  line_talker u_peer_a (.line(line_a));
  line_talker u_peer_b (.line(line_b));
  initial forever #5 clk = ~clk;
  task automatic apb(logic w, logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic par(logic [8:0] v, int m);
    return m == 1 ? ~^v : m == 2 ? ^v : m == 3;
  endfunction
  task automatic summarize;
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_count++;
    summarize;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", rd, 32'h20);
    apb(1'b0, 8'h08, 32'h0);
    chk("sbits reset", rd, 32'h19);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, perr}, 32'h1);
    // Eight cycles a bit: a non-standard rate near the fast end
    apb(1'b1, 8'h04, 32'h8);
    for (i = 0; i < 12; i++)
    begin
      n = 5 + (i * 2 + i / 5) % 5;
      p = i % 5;
      d = 9'($random(seed)) & 9'((1 << n) - 1);
      pb = p != 0 && n != 9;
      f = 10'(d) | 10'(par(d, p) ^ (i == 6)) << n;
      apb(1'b1, 8'h00, 32'(n << 2 | p << 6));
      if (i % 2)
        u_peer_b.send(f, n + pb, i != 7);
      else
        u_peer_a.send(f, n + pb, i != 7);
      apb(1'b0, i % 2 ? 8'h10 : 8'h0c, 32'h0);
      chk("rx word", rd, {19'h0, 2'b01, i == 7, pb && i == 6, d});
    end
    // SSI frame of eight clocks, then one Manchester byte sent MSB first
    d = 9'($random(seed)) & 9'h0ff;
    apb(1'b1, 8'h08, 32'h8);
    apb(1'b1, 8'h00, 32'h1);
    fork
      u_peer_a.wave(32'h0, 32'hffffffff, 8);
      u_peer_b.wave(32'(d), 32'(d), 8);
    join
    repeat (300) @(posedge clk);
    apb(1'b0, 8'h0c, 32'h0);
    chk("ssi word", rd, {19'h0, 4'h4, d});
    apb(1'b0, 8'h24, 32'h0);
    chk("ssi clocks", rd, 32'h8);
    apb(1'b0, 8'h20, 32'h0);
    chk("ssi period", rd, 32'h8);
    d = 9'($random(seed)) & 9'h07f;
    apb(1'b1, 8'h00, 32'h2002);
    u_peer_a.wave(~32'(d), 32'(d), 8);
    apb(1'b0, 8'h0c, 32'h0);
    chk("manchester byte", rd, {19'h0, 4'h4, d});
    summarize;
  end
endmodule
